// ==== verilog/pss_pkg.sv ====
// constants, carriers and helpers of the pipelined synchronous memory port
// assumes one 50 MHz clock and a host that drives all pins synchronously
`default_nettype none
package pss_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 48;
  localparam int LANES = 6;
  localparam int LANE_W = 8;
  localparam int WORDS = 2097152;
  localparam int BURST_W = 2;
  localparam logic [1:0] CNT_STEP = 2'h1;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [2:0]
  {
    OP_DESEL = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h4
  } pss_op_type;

  // synchronous host pins, sampled together
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic write_n;
    logic [LANES-1:0] byte_lane_write_n;
    logic select_a_n;
    logic select_b;
    logic select_c_n;
    logic burst_advance_or_load;
  } pss_req_type;

  // whole state of the port
  typedef struct packed {
    pss_op_type op;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] count;
    logic [LANES-1:0] lane_n;
    logic [DATA_W-1:0] dout;
    logic drive;
    logic [DATA_W-1:0] buf0;
    logic [DATA_W-1:0] buf1;
    logic [1:0] buf_cnt;
  } pss_state_type;

  localparam pss_state_type ST_RESET = '{op: OP_DESEL, default: '0};

  // word address from burst base and counter
  function automatic logic [ADDR_W-1:0] word_addr(
    input logic [ADDR_W-1:0] base,
    input logic [BURST_W-1:0] count);
    word_addr = {base[ADDR_W-1:BURST_W], count};
  endfunction : word_addr

  // next burst position, linear or interleaved
  function automatic logic [BURST_W-1:0] next_count(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] count,
    input logic interleave);
    logic [BURST_W-1:0] seq;
    seq = (count ^ start) + CNT_STEP;
    if (interleave)
      next_count = start ^ seq;
    else
      next_count = count + CNT_STEP;
  endfunction : next_count

  // lane-masked merge, low enable keeps new byte
  function automatic logic [DATA_W-1:0] merge_word(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0] lane_n);
    merge_word = old_word;
    for (int i = 0; i < LANES; i++)
    begin
      if (!lane_n[i])
        merge_word[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
    end
  endfunction : merge_word
endpackage : pss_pkg
`default_nettype wire

// ==== verilog/pss_sram.sv ====
// pipelined synchronous static memory, 2M words of 48 bits, host pin side
// assumes host pins synchronous to sys_clk; the data bus is split in three
// What this block does
// R1: holds 2M words of 48 bits, one word per access
// R2: takes a 21-bit word address at the rising edge
// R3: samples synchronous inputs only while the clock qualifier is low
// R4: qualifier high freezes all but the read buffer drain, previous operation stays, no deselect
// R5: first select is active low, combined with the other two
// R6: second select is active high, combined with the other two
// R7: third select is active low, combined with the other two
// R8: write request low at a qualified edge starts a write
// R9: six low byte enables write their lane, high masks it
// R10: low two address bits seed the two-bit burst counter
// R11: four-word bursts, linear or interleaved order
// R12: data drivers float during every write data phase
// R13: asynchronous low output enable plus selects gate the drivers
// R14: writes complete internally, no extra timing strobe needed
// R15: registered in and out, reads and writes back to back
// R16: advance high steps counter, low loads; after deselect load needed
// R17: read data appears one clock after its address edge
// R18: outputs float on write, first clock out of deselect, deselected
// R19: selected only when first low, second high, third low
// R20: host keeps the burst order fixed during operation
`default_nettype none
module pss_sram (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clock_qualifier_n,
  input wire pss_pkg::pss_req_type host_req,
  input wire logic burst_order_interleaved,
  input wire logic output_enable_n,
  input wire logic [pss_pkg::DATA_W-1:0] dq_in,
  output logic [pss_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic rdbuf_valid,
  output logic [pss_pkg::DATA_W-1:0] rdbuf_data,
  input wire logic rdbuf_ready
);
  import pss_pkg::*;

  pss_state_type st_reg;
  pss_state_type st_next;
  // R1: storage array
  logic [DATA_W-1:0] mem_array [0:WORDS-1];
  logic qualified;
  logic selected;
  logic pop;
  logic mem_we;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] rd_word;
  logic [1:0] cnt_after_pop;

  // R19: select decode of the three pins
  // R5: first select active low
  // R6: second select active high
  // R7: third select active low
  assign selected = !host_req.select_a_n && host_req.select_b &&
                    !host_req.select_c_n;

  // R3: edge counts only with qualifier low
  // a full read buffer acts as a held qualifier so no word is dropped
  assign qualified = !clock_qualifier_n && (st_reg.buf_cnt != BUF_FULL);

  // R9: write word merged per byte lane
  assign wr_addr = word_addr(st_reg.base, st_reg.count);
  assign wr_word = merge_word(mem_array[wr_addr], dq_in, st_reg.lane_n);

  // next state: pipeline, burst counter and read buffer
  always_comb
  begin
    st_next = st_reg;
    mem_we = 1'b0;
    rd_addr = wr_addr;
    rd_word = st_reg.dout;
    pop = (st_reg.buf_cnt != BUF_EMPTY) && rdbuf_ready;
    cnt_after_pop = st_reg.buf_cnt;
    // buffer drains independently of the memory pipeline
    if (pop)
    begin
      st_next.buf0 = st_reg.buf1;
      cnt_after_pop = st_reg.buf_cnt - BUF_ONE;
    end
    st_next.buf_cnt = cnt_after_pop;
    // R4: held edge keeps all state but the draining read buffer as it was
    if (qualified)
    begin
      // R12: write data phase follows the address edge
      // R14: self-timed commit in the data phase
      if (st_reg.op == OP_WRITE)
        mem_we = 1'b1;
      // R16: advance steps, load takes a new address
      if (host_req.burst_advance_or_load && st_reg.op != OP_DESEL)
      begin
        // R11: four-word burst order
        st_next.count = next_count(st_reg.start, st_reg.count,
                                   burst_order_interleaved);
        st_next.lane_n = host_req.byte_lane_write_n;
      end
      else if (!host_req.burst_advance_or_load && selected)
      begin
        // R8: low write request opens a write
        st_next.op = host_req.write_n ? OP_READ : OP_WRITE;
        // R2: word address captured
        st_next.base = host_req.address;
        // R10: counter seeded from low address bits
        st_next.start = host_req.address[BURST_W-1:0];
        st_next.count = host_req.address[BURST_W-1:0];
        st_next.lane_n = host_req.byte_lane_write_n;
      end
      else
      begin
        // advance after deselect stays deselected
        st_next.op = OP_DESEL;
      end
      // R18: drive only for a read data phase
      st_next.drive = (st_next.op == OP_READ);
      rd_addr = word_addr(st_next.base, st_next.count);
      if (st_next.op == OP_READ)
      begin
        // R15: forward a write landing on the same word this edge
        if (mem_we && wr_addr == rd_addr)
          rd_word = wr_word;
        else
          rd_word = mem_array[rd_addr];
        // R17: read word registered at its address edge
        st_next.dout = rd_word;
        if (cnt_after_pop == BUF_EMPTY)
          st_next.buf0 = rd_word;
        else
          st_next.buf1 = rd_word;
        st_next.buf_cnt = cnt_after_pop + BUF_ONE;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_reg <= ST_RESET;
    else
      st_reg <= st_next;
  end

  // memory array has no reset, contents undefined until written
  always_ff @(posedge sys_clk)
  begin
    if (mem_we && !rst)
      mem_array[wr_addr] <= wr_word;
  end

  // R13: asynchronous output enable gates the synchronous drive
  assign dq_oe = st_reg.drive && !output_enable_n;
  assign dq_out = st_reg.dout;
  assign rdbuf_valid = (st_reg.buf_cnt != BUF_EMPTY);
  assign rdbuf_data = st_reg.buf0;

  // checks below watch design state and outputs, with host inputs in their antecedents
  // held edges are the main hazard: a stray commit corrupts a word
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // R4: held edge freezes state
  hold_freeze_a: assert property ( // R4
    !qualified && !pop |=> st_reg == $past(st_reg))
    else $error("state moved during a held edge");

  // R17: read one clock later
  read_latency_a: assert property ( // R17
    qualified && !host_req.burst_advance_or_load && selected &&
    host_req.write_n |=> st_reg.drive && st_reg.op == OP_READ)
    else $error("read data not driven one clock after address");

  // R12: write phase floats, commits
  write_float_a: assert property ( // R12
    qualified && !host_req.burst_advance_or_load && selected &&
    !host_req.write_n |=> !dq_oe && (!qualified || mem_we))
    else $error("drivers on or no commit in write data phase");

  // R18: deselect floats outputs
  desel_float_a: assert property ( // R18
    qualified && !host_req.burst_advance_or_load && !selected
    |=> !dq_oe && st_reg.op == OP_DESEL)
    else $error("deselected port drives the bus");

  // R13: output enable gates
  oe_gate_a: assert property ( // R13
    output_enable_n |-> !dq_oe)
    else $error("drivers on with output enable high");

  // R11: linear burst step
  burst_linear_a: assert property ( // R11
    qualified && host_req.burst_advance_or_load &&
    st_reg.op != OP_DESEL && !burst_order_interleaved
    |=> st_reg.count == $past(st_reg.count) + CNT_STEP)
    else $error("linear burst did not step by one");

  // R10: counter seeded on load
  load_count_a: assert property ( // R10
    qualified && !host_req.burst_advance_or_load && selected
    |=> st_reg.count == $past(host_req.address[BURST_W-1:0]))
    else $error("burst counter not seeded from address");

  // R19: partial selects deselect
  select_decode_a: assert property ( // R19
    qualified && !host_req.burst_advance_or_load &&
    (host_req.select_a_n || !host_req.select_b || host_req.select_c_n)
    |=> st_reg.op == OP_DESEL)
    else $error("partial select combination selected the port");

  // R15: full buffer keeps words
  buffer_keep_a: assert property ( // R15
    st_reg.buf_cnt == BUF_FULL && !rdbuf_ready
    |=> st_reg.buf_cnt == BUF_FULL && $stable(st_reg.buf0))
    else $error("full read buffer lost or moved a word");

  // R18: reset leaves port quiet
  // reset itself is the antecedent, so this one is never disabled
  reset_quiet_a: assert property ( // R18
    disable iff (1'b0)
    rst |=> st_reg.op == OP_DESEL && !dq_oe && !rdbuf_valid)
    else $error("port not deselected and empty after reset");

  // R15: buffer never overfills
  buf_bound_a: assert property ( // R15
    st_reg.buf_cnt <= BUF_FULL)
    else $error("read buffer count beyond two");

  // R15: full buffer stalls pipeline
  full_stall_a: assert property ( // R15
    st_reg.buf_cnt == BUF_FULL |-> !qualified)
    else $error("pipeline ran with a full read buffer");

  // R15: pop shifts second word
  pop_shift_a: assert property ( // R15
    st_reg.buf_cnt == BUF_FULL && rdbuf_ready
    |=> rdbuf_data == $past(st_reg.buf1))
    else $error("second buffered word not moved to the head");

  // R15: stalled head stays put
  head_stable_a: assert property ( // R15
    rdbuf_valid && !rdbuf_ready && !qualified
    |=> rdbuf_valid && $stable(rdbuf_data))
    else $error("stalled buffer head changed or vanished");

  // R17: first read reaches buffer
  push_first_a: assert property ( // R17
    qualified && !host_req.burst_advance_or_load && selected &&
    host_req.write_n && st_reg.buf_cnt == BUF_EMPTY
    |=> rdbuf_valid && rdbuf_data == dq_out)
    else $error("read word not placed at the buffer head");

  // R4: qualifier high holds output
  held_output_a: assert property ( // R4
    clock_qualifier_n |=> $stable(dq_out) && $stable(st_reg.drive))
    else $error("output moved while the qualifier was high");

  // R14: data phase commits itself
  commit_data_a: assert property ( // R14
    qualified && st_reg.op == OP_WRITE |-> mem_we)
    else $error("qualified write data phase did not commit");

  // R3: held edge never commits
  held_no_commit_a: assert property ( // R3
    !qualified |-> !mem_we)
    else $error("memory written on a held edge");

  // R8: commits only for writes
  commit_only_write_a: assert property ( // R8
    mem_we |-> st_reg.op == OP_WRITE)
    else $error("memory written outside a write");

  // R8: low request opens write
  write_op_a: assert property ( // R8
    qualified && !host_req.burst_advance_or_load && selected &&
    !host_req.write_n |=> st_reg.op == OP_WRITE)
    else $error("low write request did not open a write");

  // R9: lane enables captured
  lane_capture_a: assert property ( // R9
    qualified && !host_req.burst_advance_or_load && selected
    |=> st_reg.lane_n == $past(host_req.byte_lane_write_n))
    else $error("byte lane enables not captured on load");

  // R9: all lanes masked keeps word
  lane_mask_a: assert property ( // R9
    mem_we && (&st_reg.lane_n) |-> wr_word == mem_array[wr_addr])
    else $error("masked lanes altered the stored word");

  // R9: all lanes enabled takes data
  lane_full_a: assert property ( // R9
    mem_we && st_reg.lane_n == '0 |-> wr_word == dq_in)
    else $error("enabled lanes did not take the input data");

  // R2: address captured on load
  addr_capture_a: assert property ( // R2
    qualified && !host_req.burst_advance_or_load && selected
    |=> st_reg.base == $past(host_req.address))
    else $error("word address not captured on load");

  // R11: interleaved burst step
  burst_interleave_a: assert property ( // R11
    qualified && host_req.burst_advance_or_load &&
    st_reg.op != OP_DESEL && burst_order_interleaved
    |=> (st_reg.count ^ st_reg.start) ==
        $past(st_reg.count ^ st_reg.start) + CNT_STEP)
    else $error("interleaved burst took a wrong step");

  // R16: advance keeps base
  base_fixed_a: assert property ( // R16
    qualified && host_req.burst_advance_or_load
    |=> $stable(st_reg.base))
    else $error("advance changed the burst base");

  // R16: advance after deselect idles
  adv_desel_a: assert property ( // R16
    qualified && host_req.burst_advance_or_load &&
    st_reg.op == OP_DESEL |=> st_reg.op == OP_DESEL)
    else $error("advance after deselect started an access");

  // R16: advance keeps operation
  adv_keep_op_a: assert property ( // R16
    qualified && host_req.burst_advance_or_load &&
    st_reg.op != OP_DESEL |=> st_reg.op == $past(st_reg.op))
    else $error("advance changed the burst operation");

  // R18: drive only in read
  drive_read_a: assert property ( // R18
    st_reg.drive |-> st_reg.op == OP_READ)
    else $error("drive set outside a read");

  // R18: deselected never drives
  desel_out_a: assert property ( // R18
    st_reg.op == OP_DESEL |-> !dq_oe)
    else $error("drivers on while deselected");

  // R12: write never drives
  write_out_a: assert property ( // R12
    st_reg.op == OP_WRITE |-> !dq_oe)
    else $error("drivers on during a write");

  // R13: enable low passes drive
  oe_follow_a: assert property ( // R13
    st_reg.drive && !output_enable_n |-> dq_oe)
    else $error("read data not driven with output enable low");

endmodule : pss_sram
`default_nettype wire

// ==== tb/pss_sink.sv ====
// read-buffer consumer model of the host side of the memory port
// assumes the bench sets stall between clock edges
`default_nettype none
module pss_sink (
  input wire logic sys_clk,
  input wire logic stall,
  output var logic rdbuf_ready = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // ready lags stall by one edge, like a slow bus master
  always @(posedge sys_clk)
    rdbuf_ready <= #2 !stall;
endmodule : pss_sink
`default_nettype wire

// ==== tb/test_pipelined_sync_sram_port.sv ====
// self-checking bench of the pipelined memory port
// assumes one host driver and the read-buffer sink model
`default_nettype none
module test_pipelined_sync_sram_port;
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic clock_qualifier_n = 1'h0;
  pss_req_type host_req = '0;
  logic burst_order_interleaved = 1'h0;
  logic output_enable_n = 1'h0;
  logic [DATA_W-1:0] dq_in = '0;
  logic [DATA_W-1:0] dq_out, rdbuf_data, pend;
  logic dq_oe, rdbuf_valid, rdbuf_ready;
  logic stall = 1'h0;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] expq [$];
  logic [31:0] seed = 32'h0001146D;
  int n_fail = 0;
  int tests_run = 0;

  pss_sram u_pss_sram (.sys_clk(sys_clk), .rst(rst),
    .clock_qualifier_n(clock_qualifier_n), .host_req(host_req),
    .burst_order_interleaved(burst_order_interleaved),
    .output_enable_n(output_enable_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .rdbuf_valid(rdbuf_valid), .rdbuf_data(rdbuf_data),
    .rdbuf_ready(rdbuf_ready));
  pss_sink u_pss_sink (.sys_clk(sys_clk), .stall(stall),
    .rdbuf_ready(rdbuf_ready));

  // free-running 50 MHz clock
  initial
    forever #10 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'hA3000000 : seed >> 1;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // one qualified cycle; write data follows in the next cycle
  task automatic op(input logic rd, input logic [2:0] s, input logic adv,
    input logic [ADDR_W-1:0] ad, input logic [LANES-1:0] l);
    logic [DATA_W-1:0] m;
    logic ok;
    ok = (s == 3'h2);
    m = mem.exists(ad) ? mem[ad] : 'x;
    host_req = '{address: ad, write_n: rd, byte_lane_write_n: l,
      select_a_n: s[2], select_b: s[1], select_c_n: s[0],
      burst_advance_or_load: adv};
    dq_in = pend;
    pend = 48'({rnd(), rnd()});
    if (!rd && ok)
    begin
      for (int i = 0; i < LANES; i++)
        if (!l[i])
          m[i*LANE_W +: LANE_W] = pend[i*LANE_W +: LANE_W];
      mem[ad] = m;
    end
    if (rd && ok)
      expq.push_back(m);
    @(posedge sys_clk);
    #2;
    // drive only after a selected read
    chk(dq_oe, rd && ok && !output_enable_n);
    if (rd && ok)
      chk(dq_out, m);
  endtask : op

  // held edge with a would-be read load
  task automatic hold(input logic e);
    clock_qualifier_n = 1'h1;
    host_req.write_n = 1'h1;
    host_req.burst_advance_or_load = 1'h0;
    @(posedge sys_clk);
    #2;
    chk(dq_oe, e);
    clock_qualifier_n = 1'h0;
  endtask : hold

  // fill a group, then one four-word burst read
  task automatic burst(input logic il);
    logic [ADDR_W-1:0] b;
    b = ADDR_W'(rnd());
    burst_order_interleaved = il;
    for (int k = 0; k < 4; k++)
      op(1'h0, 3'h2, 1'h0, {b[20:2], 2'(k)}, 6'h00);
    for (int k = 0; k < 4; k++)
      op(1'h1, 3'h2, k != 0,
        {b[20:2], il ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)}, 6'h3F);
  endtask : burst

  // every popped word matches the oldest note
  always @(posedge sys_clk)
    if (rdbuf_valid && rdbuf_ready)
      chk(rdbuf_data, expq.pop_front());

  // watchdog well beyond the some sixty cycles of the run
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end

  initial
  begin
    pend = '0;
    repeat (16) @(posedge sys_clk);
    #2;
    rst = 1'h0;
    a = ADDR_W'(rnd());
    // full write, lane write, reads back to back
    op(1'h0, 3'h2, 1'h0, a, 6'h00);
    op(1'h0, 3'h2, 1'h0, a, LANES'(rnd()));
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    $display("test 1 done");
    burst(1'h0);
    burst(1'h1);
    $display("test 2 done");
    // pending write survives a held edge
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    hold(1'h1);
    op(1'h0, 3'h2, 1'h0, a, 6'h00);
    hold(1'h0);
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    $display("test 3 done");
    for (int s = 0; s < 8; s++)
      if (s != 2)
        op(1'h1, 3'(s), 1'h0, a, 6'h3F);
    output_enable_n = 1'h1;
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    $display("test 4 done");
    // buffer fills while the sink stalls, then drains
    stall = 1'h1;
    op(1'h1, 3'h0, 1'h0, a, 6'h3F);
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    op(1'h1, 3'h2, 1'h0, a, 6'h3F);
    op(1'h1, 3'h0, 1'h0, a, 6'h3F);
    chk(rdbuf_valid, 1'h1);
    stall = 1'h0;
    repeat (4) op(1'h1, 3'h0, 1'h0, a, 6'h3F);
    chk(expq.size(), 0);
    $display("test 5 done");
    conclude();
  end
endmodule : test_pipelined_sync_sram_port
`default_nettype wire
